//--- shared/bst_pkg.sv
// Constants, codes and state encoding for the boundary-scan test registers.
// Assumes one test port per device, instruction register three bits wide.
package bst_pkg;

	// Instruction register
	localparam int BST_IR_W = 3;
	localparam logic [2:0] BST_IR_EXTEST = 3'h0;
	localparam logic [2:0] BST_IR_HIGHZ = 3'h2;
	localparam logic [2:0] BST_IR_CLAMP = 3'h3;
	localparam logic [2:0] BST_IR_SAMPLE = 3'h4;
	localparam logic [2:0] BST_IR_IDCODE = 3'h6;
	localparam logic [2:0] BST_IR_BYPASS = 3'h7;
	// Fixed pattern loaded in Capture-IR, low two bits as the standard wants
	localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
	localparam logic [2:0] BST_IR_RESET = BST_IR_IDCODE;

	// Identification register layout
	localparam int BST_ID_W = 32;
	localparam int BST_ID_MFR_W = 11;
	localparam int BST_ID_PART_W = 16;
	localparam int BST_ID_VER_W = 4;
	localparam int BST_ID_MFR_LSB = 1;
	localparam int BST_ID_PART_LSB = 12;
	localparam int BST_ID_VER_LSB = 28;
	localparam logic BST_ID_LSB_VAL = 1'b1;

	// Bypass capture value and serial output idle level
	localparam logic BST_BYP_CAPTURE = 1'b0;
	localparam logic BST_TDO_IDLE = 1'b0;

	// Synchroniser depth for every crossing
	localparam int BST_SYNC_STAGES = 2;

	// Test access port controller, one-hot
	typedef enum logic [15:0] {
		BST_TLR = 16'h0001,
		BST_RTI = 16'h0002,
		BST_SEL_DR = 16'h0004,
		BST_CAP_DR = 16'h0008,
		BST_SHF_DR = 16'h0010,
		BST_EX1_DR = 16'h0020,
		BST_PAU_DR = 16'h0040,
		BST_EX2_DR = 16'h0080,
		BST_UPD_DR = 16'h0100,
		BST_SEL_IR = 16'h0200,
		BST_CAP_IR = 16'h0400,
		BST_SHF_IR = 16'h0800,
		BST_EX1_IR = 16'h1000,
		BST_PAU_IR = 16'h2000,
		BST_EX2_IR = 16'h4000,
		BST_UPD_IR = 16'h8000
	} bst_tap_t;

endpackage

//--- hw/bst_word_xfer.sv
// Request/acknowledge crossing of one word from the test clock domain
// to the system clock domain. Sends again whenever the source word changes.
`timescale 1ns/100ps
module bst_word_xfer
	import bst_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic src_clk,
	input wire logic src_rst_n,
	input wire logic [W-1:0] src_word,
	input wire logic dst_clk,
	input wire logic dst_rst_n,
	output logic [W-1:0] dst_word
);

	logic [W-1:0] hold_ff;
	logic req_ff;
	logic ack_meta_ff;
	logic ack_sync_ff;
	logic req_meta_ff;
	logic req_sync_ff;
	logic seen_ff;
	logic [W-1:0] dst_word_ff;
	logic busy;

	assign busy = req_ff != ack_sync_ff;

	// Hold stays frozen while a request is in flight, so the far side reads a settled word
	always_ff @(posedge src_clk) begin
		if (!src_rst_n) begin
			hold_ff <= '0;
			req_ff <= 1'b0;
		end else if (!busy && src_word != hold_ff) begin
			hold_ff <= src_word;
			req_ff <= ~req_ff;
		end
	end

	always_ff @(posedge src_clk) begin
		if (!src_rst_n) begin
			ack_meta_ff <= 1'b0;
			ack_sync_ff <= 1'b0;
		end else begin
			ack_meta_ff <= seen_ff;
			ack_sync_ff <= ack_meta_ff;
		end
	end

	always_ff @(posedge dst_clk) begin
		if (!dst_rst_n) begin
			req_meta_ff <= 1'b0;
			req_sync_ff <= 1'b0;
			seen_ff <= 1'b0;
			dst_word_ff <= '0;
		end else begin
			req_meta_ff <= req_ff;
			req_sync_ff <= req_meta_ff;
			seen_ff <= req_sync_ff;
			if (req_sync_ff != seen_ff) begin
				dst_word_ff <= hold_ff;
			end
		end
	end

	assign dst_word = dst_word_ff;

endmodule // bst_word_xfer

//--- hw/bst_scan_regs.sv
// What this block does
// R01: Bypass, boundary and identification data registers
// R02: One-stage bypass for BYPASS, CLAMP, HIGHZ
// R03: Identification: 32-bit shift plus parallel latch
// R04: Identification selected by IDCODE and Test-Logic-Reset
// R05: Identification bit zero always one
// R06: Fields: manufacturer 11, part 16, version 4
// R07: Boundary register: shift path plus parallel latch
// R08: Stopped test clock keeps all state
// R09: IDCODE captures the identification latch in Capture-DR
// R10: Selected register shifts, others hold
// R11: Parallel latches load on falling edge, Update-DR
// R12: Three-bit instruction register, shift and latch
// R13: Bypass captures zero; shifts least significant first
//
// Test access port with its data registers, on the test clock.
// Assumes test_mode_select and test_data_in are timed to test_clock; pad_in is
// asynchronous; core_out and core_oe come from logic on clk.
`timescale 1ns/100ps
module bst_scan_regs
	import bst_pkg::*;
#(
	parameter int N_IN = 8,
	parameter int N_OUT = 8,
	parameter logic [10:0] MFR_ID = 11'h055, // Arbitrary value
	parameter logic [15:0] PART_ID = 16'h1234, // Arbitrary value
	parameter logic [3:0] VER_ID = 4'h1 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic test_clock,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	output logic test_data_out,
	output logic test_data_out_en,
	input wire logic [N_IN-1:0] pad_in,
	input wire logic [N_OUT-1:0] core_out,
	input wire logic core_oe,
	output logic [N_OUT-1:0] pad_out,
	output logic pad_oe
);

	// Boundary cells: inputs, then outputs, then one output-enable control cell
	localparam int BSR_W = N_IN + N_OUT + 1;
	localparam int CTL_POS = N_IN + N_OUT;
	localparam int XW = N_OUT + 3;

	logic trst_meta_ff;
	logic trst_ff;
	logic [N_IN-1:0] pin_meta_ff;
	logic [N_IN-1:0] pin_sync_ff;
	bst_tap_t state_ff;
	bst_tap_t nxt_state;
	logic [BST_IR_W-1:0] ir_sh_ff;
	logic [BST_IR_W-1:0] ir_par_ff;
	logic byp_ff;
	logic [BST_ID_W-1:0] dr_id_ff;
	logic [BST_ID_W-1:0] id_latch_ff;
	logic [BSR_W-1:0] bsr_sh_ff;
	logic [BSR_W-1:0] bsr_par_ff;
	logic tdo_ff;
	logic tdo_en_ff;
	logic [N_OUT-1:0] pad_out_ff;
	logic pad_oe_ff;
	logic sel_id;
	logic sel_bsr;
	logic sel_byp;
	logic drive_bsr;
	logic highz;
	logic [BST_ID_W-1:0] id_code;
	logic [BSR_W-1:0] bsr_capture;
	logic [XW-1:0] xfer_src;
	logic [XW-1:0] xfer_dst;

	assign id_code = {VER_ID, PART_ID, MFR_ID, BST_ID_LSB_VAL}; // R06 R05

	// Reset reaches the test clock domain through two flops
	always_ff @(posedge test_clock) begin
		trst_meta_ff <= rst_n;
		trst_ff <= trst_meta_ff;
	end

	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
		end else begin
			pin_meta_ff <= pad_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Controller; every flop here only moves on a test clock edge
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			BST_TLR: nxt_state = test_mode_select ? BST_TLR : BST_RTI;
			BST_RTI: nxt_state = test_mode_select ? BST_SEL_DR : BST_RTI;
			BST_SEL_DR: nxt_state = test_mode_select ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: nxt_state = test_mode_select ? BST_EX1_DR : BST_SHF_DR;
			BST_SHF_DR: nxt_state = test_mode_select ? BST_EX1_DR : BST_SHF_DR;
			BST_EX1_DR: nxt_state = test_mode_select ? BST_UPD_DR : BST_PAU_DR;
			BST_PAU_DR: nxt_state = test_mode_select ? BST_EX2_DR : BST_PAU_DR;
			BST_EX2_DR: nxt_state = test_mode_select ? BST_UPD_DR : BST_SHF_DR;
			BST_UPD_DR: nxt_state = test_mode_select ? BST_SEL_DR : BST_RTI;
			BST_SEL_IR: nxt_state = test_mode_select ? BST_TLR : BST_CAP_IR;
			BST_CAP_IR: nxt_state = test_mode_select ? BST_EX1_IR : BST_SHF_IR;
			BST_SHF_IR: nxt_state = test_mode_select ? BST_EX1_IR : BST_SHF_IR;
			BST_EX1_IR: nxt_state = test_mode_select ? BST_UPD_IR : BST_PAU_IR;
			BST_PAU_IR: nxt_state = test_mode_select ? BST_EX2_IR : BST_PAU_IR;
			BST_EX2_IR: nxt_state = test_mode_select ? BST_UPD_IR : BST_SHF_IR;
			BST_UPD_IR: nxt_state = test_mode_select ? BST_SEL_DR : BST_RTI;
			default: nxt_state = BST_TLR;
		endcase
	end

	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			state_ff <= BST_TLR;
		end else begin
			state_ff <= nxt_state; // R08
		end
	end

	// Instruction decode; unknown codes fall back to bypass
	always_comb begin
		sel_id = ir_par_ff == BST_IR_IDCODE; // R04
		sel_bsr = ir_par_ff == BST_IR_EXTEST || ir_par_ff == BST_IR_SAMPLE; // R01
		sel_byp = !sel_id && !sel_bsr; // R02
		drive_bsr = ir_par_ff == BST_IR_EXTEST || ir_par_ff == BST_IR_CLAMP;
		highz = ir_par_ff == BST_IR_HIGHZ;
	end

	// Instruction shift stage, least significant bit toward the output
	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			ir_sh_ff <= BST_IR_CAPTURE;
		end else if (state_ff == BST_CAP_IR) begin
			ir_sh_ff <= BST_IR_CAPTURE; // R12
		end else if (state_ff == BST_SHF_IR) begin
			ir_sh_ff <= {test_data_in, ir_sh_ff[BST_IR_W-1:1]}; // R12 R13
		end
	end

	// Parallel latches change on the falling edge, so shifting never shows through
	always_ff @(negedge test_clock) begin
		if (!trst_ff || state_ff == BST_TLR) begin
			ir_par_ff <= BST_IR_RESET; // R04
		end else if (state_ff == BST_UPD_IR) begin
			ir_par_ff <= ir_sh_ff; // R12
		end
	end

	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			byp_ff <= BST_BYP_CAPTURE;
		end else if (sel_byp && state_ff == BST_CAP_DR) begin
			byp_ff <= BST_BYP_CAPTURE; // R13
		end else if (sel_byp && state_ff == BST_SHF_DR) begin
			byp_ff <= test_data_in; // R02 R10
		end
	end

	// Identification shift stage loads from its own latch
	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			dr_id_ff <= id_code;
		end else if (sel_id && state_ff == BST_CAP_DR) begin
			dr_id_ff <= id_latch_ff; // R09
		end else if (sel_id && state_ff == BST_SHF_DR) begin
			dr_id_ff <= {test_data_in, dr_id_ff[BST_ID_W-1:1]}; // R10 R13
		end
	end

	// Latch is refreshed with the code in reset; bit zero stays one regardless
	always_ff @(negedge test_clock) begin
		if (!trst_ff || state_ff == BST_TLR) begin
			id_latch_ff <= id_code; // R03
		end else if (sel_id && state_ff == BST_UPD_DR) begin
			id_latch_ff <= {dr_id_ff[BST_ID_W-1:1], BST_ID_LSB_VAL}; // R03 R11 R05
		end
	end

	// Output and control cells capture their own latch, input cells the pins
	assign bsr_capture = {bsr_par_ff[BSR_W-1:N_IN], pin_sync_ff};

	always_ff @(posedge test_clock) begin
		if (!trst_ff) begin
			bsr_sh_ff <= '0;
		end else if (sel_bsr && state_ff == BST_CAP_DR) begin
			bsr_sh_ff <= bsr_capture; // R07
		end else if (sel_bsr && state_ff == BST_SHF_DR) begin
			bsr_sh_ff <= {test_data_in, bsr_sh_ff[BSR_W-1:1]}; // R07 R10 R13
		end
	end

	always_ff @(negedge test_clock) begin
		if (!trst_ff) begin
			bsr_par_ff <= '0;
		end else if (sel_bsr && state_ff == BST_UPD_DR) begin
			bsr_par_ff <= bsr_sh_ff; // R07 R11
		end
	end

	// Serial output moves on the falling edge to give the far end half a period
	always_ff @(negedge test_clock) begin
		if (!trst_ff) begin
			tdo_ff <= BST_TDO_IDLE;
			tdo_en_ff <= 1'b0;
		end else if (state_ff == BST_SHF_IR) begin
			tdo_ff <= ir_sh_ff[0];
			tdo_en_ff <= 1'b1;
		end else if (state_ff == BST_SHF_DR) begin
			tdo_ff <= sel_id ? dr_id_ff[0] : (sel_bsr ? bsr_sh_ff[0] : byp_ff); // R10
			tdo_en_ff <= 1'b1;
		end else begin
			tdo_ff <= BST_TDO_IDLE;
			tdo_en_ff <= 1'b0;
		end
	end

	assign test_data_out = tdo_ff;
	assign test_data_out_en = tdo_en_ff;

	// Pad control crosses to clk; a stopped test clock delays a pending word
	assign xfer_src = {highz, drive_bsr, bsr_par_ff[CTL_POS], bsr_par_ff[CTL_POS-1:N_IN]};

	bst_word_xfer #(
		.W(XW)
	) u_xfer (
		.src_clk(test_clock),
		.src_rst_n(trst_ff),
		.src_word(xfer_src),
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.dst_word(xfer_dst)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pad_out_ff <= '0;
			pad_oe_ff <= 1'b0;
		end else begin
			pad_out_ff <= xfer_dst[XW-2] ? xfer_dst[N_OUT-1:0] : core_out;
			pad_oe_ff <= xfer_dst[XW-1] ? 1'b0 : (xfer_dst[XW-2] ? xfer_dst[N_OUT] : core_oe);
		end
	end

	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;

	// Checks on the test clock
	a_tlr_sel_id: assert property (@(posedge test_clock) disable iff (!trst_ff) // R04
		($past(state_ff) == BST_TLR && state_ff == BST_TLR) |-> sel_id)
		else $error("identification not selected in reset state");

	a_tms_to_tlr: assert property (@(posedge test_clock) disable iff (!trst_ff) // R04
		test_mode_select [*5] |=> state_ff == BST_TLR)
		else $error("five high mode selects did not reach reset state");

	a_id_lsb_one: assert property (@(posedge test_clock) disable iff (!trst_ff) // R05
		id_latch_ff[0] == 1'b1)
		else $error("identification latch bit zero not one");

	a_id_capture: assert property (@(posedge test_clock) disable iff (!trst_ff) // R09
		(state_ff == BST_CAP_DR && sel_id) |=> dr_id_ff == $past(id_latch_ff))
		else $error("identification code not captured");

	a_id_shift: assert property (@(posedge test_clock) disable iff (!trst_ff) // R10
		(state_ff == BST_SHF_DR && sel_id)
		|=> dr_id_ff == {$past(test_data_in), $past(dr_id_ff[BST_ID_W-1:1])})
		else $error("identification register did not shift");

	a_byp_path: assert property (@(posedge test_clock) disable iff (!trst_ff) // R02
		(state_ff == BST_SHF_DR && sel_byp) |=> byp_ff == $past(test_data_in))
		else $error("bypass stage did not take serial input");

	a_byp_zero: assert property (@(posedge test_clock) disable iff (!trst_ff) // R13
		(state_ff == BST_CAP_DR && sel_byp) |=> byp_ff == 1'b0)
		else $error("bypass stage did not capture zero");

	a_unsel_hold: assert property (@(posedge test_clock) disable iff (!trst_ff) // R10
		(state_ff == BST_SHF_DR && !sel_bsr) |=> $stable(bsr_sh_ff))
		else $error("unselected boundary register moved");

	a_par_stable: assert property (@(posedge test_clock) disable iff (!trst_ff) // R11
		(state_ff == BST_SHF_DR) ##1 (state_ff == BST_SHF_DR) |-> $stable(bsr_par_ff))
		else $error("boundary latch changed while shifting");

	a_ir_shift: assert property (@(posedge test_clock) disable iff (!trst_ff) // R12
		(state_ff == BST_SHF_IR)
		|=> ir_sh_ff == {$past(test_data_in), $past(ir_sh_ff[BST_IR_W-1:1])})
		else $error("instruction stage did not shift");

	a_tdo_quiet: assert property (@(posedge test_clock) disable iff (!trst_ff) // R10
		(state_ff == BST_RTI) ##1 (state_ff == BST_RTI) |-> !test_data_out_en)
		else $error("serial output driven outside shift");

	a_ir_update: assert property (@(posedge test_clock) disable iff (!trst_ff) // R12
		(state_ff == BST_UPD_IR) |-> ir_par_ff == ir_sh_ff)
		else $error("instruction latch did not take shifted code");

	a_id_update: assert property (@(posedge test_clock) disable iff (!trst_ff) // R11
		(state_ff == BST_UPD_DR && sel_id) |-> id_latch_ff == {dr_id_ff[BST_ID_W-1:1], 1'b1})
		else $error("identification latch did not take shifted word");

endmodule // bst_scan_regs

//--- test/bst_ctrl_model.sv
// Behavioural boundary-scan controller driving the test port.
// Assumes the device samples mode and data on the rising test clock edge.
`timescale 1ns/100ps
module bst_ctrl_model (
	output logic test_clock,
	output logic test_mode_select,
	output logic test_data_in,
	input wire logic test_data_out,
	input wire logic test_data_out_en
);
	int stop_ns = 0;
	int en_miss = 0;
	logic en_seen = 1'h0;

	// Clock stands low outside frames
	initial begin
		test_clock = 1'h0;
		test_mode_select = 1'h1;
		test_data_in = 1'h0;
	end

	task automatic step(input logic tms, input logic tdi, output logic tdo);
		test_mode_select = tms;
		test_data_in = tdi;
		#32;
		test_clock = 1'h1;
		tdo = test_data_out;
		// Enable taken at the rising edge, where it has settled since the falling one
		en_seen = test_data_out_en;
		// Optional stop with the clock high
		#(32 + stop_ns);
		test_clock = 1'h0;
	endtask

	task automatic reset_tap();
		logic d;
		repeat (5) step(1'h1, ~test_data_in, d);
	endtask

	// From reset or idle: scan n bits, least significant first, end in idle
	task automatic scan(input logic ir, input logic [63:0] din, input int n,
		output logic [63:0] dout);
		logic d;
		dout = '0;
		step(1'h0, ~test_data_in, d);
		step(1'h1, ~test_data_in, d);
		if (ir)
			step(1'h1, ~test_data_in, d);
		step(1'h0, ~test_data_in, d);
		step(1'h0, ~test_data_in, d);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], d);
			dout[i] = d;
			if (en_seen !== 1'h1)
				en_miss++;
		end
		step(1'h1, ~test_data_in, d);
		// Idle edges let the pad word cross
		repeat (4) step(1'h0, ~test_data_in, d);
	endtask
endmodule // bst_ctrl_model

//--- test/tb.sv
// Self-checking bench for the boundary-scan test registers.
// Assumes the controller model in bst_ctrl_model drives the test port.
`timescale 1ns/100ps
module tb;
	import bst_pkg::*;
	localparam int N_IN = 8;
	localparam int N_OUT = 8;
	localparam int BSR_W = N_IN + N_OUT + 1;
	localparam logic [10:0] MFR = 11'h2A3; // Arbitrary value
	localparam logic [15:0] PART = 16'hC5E1; // Arbitrary value
	localparam logic [3:0] VER = 4'h9; // Arbitrary value
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic test_clock, test_mode_select, test_data_in, test_data_out, test_data_out_en;
	logic [N_IN-1:0] pad_in = '0;
	logic [N_OUT-1:0] core_out = '0;
	logic core_oe = 1'h0;
	logic [N_OUT-1:0] pad_out;
	logic pad_oe;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 66325;
	logic [63:0] din, dout, prev;
	logic [2:0] codes [4] = '{BST_IR_BYPASS, BST_IR_CLAMP, BST_IR_HIGHZ, 3'h5};

	always #12.5 clk = ~clk;

	bst_scan_regs #(.N_IN(N_IN), .N_OUT(N_OUT), .MFR_ID(MFR), .PART_ID(PART),
		.VER_ID(VER)) dut_u (.clk(clk), .rst_n(rst_n), .test_clock(test_clock),
		.test_mode_select(test_mode_select), .test_data_in(test_data_in),
		.test_data_out(test_data_out), .test_data_out_en(test_data_out_en),
		.pad_in(pad_in), .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out),
		.pad_oe(pad_oe));

	bst_ctrl_model ctrl_u (.test_clock(test_clock), .test_mode_select(test_mode_select),
		.test_data_in(test_data_in), .test_data_out(test_data_out),
		.test_data_out_en(test_data_out_en));

	function automatic logic [63:0] id_code();
		return {32'h0, VER, PART, MFR, 1'h1};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic load_ir(input logic [2:0] code);
		logic [63:0] d;
		ctrl_u.scan(1'h1, 64'(code), 3, d);
		chk(d[2:0], BST_IR_CAPTURE);
	endtask

	task automatic scan_dr(input int n);
		din = {$random(seed), $random(seed)};
		ctrl_u.scan(1'h0, din, n, dout);
		repeat (8) @(posedge clk);
	endtask

	// Long enough for every scan below with wide margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end

	initial begin
		fork
			repeat (16) @(posedge clk);
			ctrl_u.reset_tap();
		join
		@(posedge clk);
		rst_n <= 1'h1;
		core_out <= N_OUT'($random(seed));
		core_oe <= 1'h1;
		ctrl_u.reset_tap();
		scan_dr(32);
		chk(dout, id_code());
		chk({pad_oe, pad_out}, {core_oe, core_out});
		prev = din;
		// Capture reads the latch, so the last word shifted in comes back
		load_ir(BST_IR_IDCODE);
		scan_dr(32);
		chk(dout, {32'h0, prev[31:1], 1'h1});
		prev = din;
		scan_dr(32);
		chk(dout, {32'h0, prev[31:1], 1'h1});
		ctrl_u.reset_tap();
		#3000;
		ctrl_u.stop_ns = 2000;
		scan_dr(32);
		ctrl_u.stop_ns = 0;
		chk(dout, id_code());
		foreach (codes[k]) begin
			load_ir(codes[k]);
			scan_dr(32);
			chk(dout, {32'h0, din[30:0], 1'h0});
			if (codes[k] == BST_IR_HIGHZ)
				chk(pad_oe, 1'h0);
		end
		load_ir(BST_IR_SAMPLE);
		@(posedge clk);
		pad_in <= N_IN'($random(seed));
		core_out <= N_OUT'($random(seed));
		scan_dr(BSR_W);
		chk(dout[N_IN-1:0], pad_in);
		chk({pad_oe, pad_out}, {core_oe, core_out});
		prev = din;
		load_ir(BST_IR_EXTEST);
		repeat (8) @(posedge clk);
		chk({pad_oe, pad_out}, prev[BSR_W-1:N_IN]);
		scan_dr(BSR_W);
		chk(dout[BSR_W-1:N_IN], prev[BSR_W-1:N_IN]);
		chk({test_data_out_en, 31'(ctrl_u.en_miss)}, 32'h0);
		end_sim();
	end
endmodule // tb
